//--- hdl/pmi_intr.sv
`default_nettype none
// How it works
// (RQ1) control bit 1 lets the event flags drive the interrupt output when 1 and blocks them when 0, reset 0.
// (RQ2) control bit 2 forces the interrupt output active regardless of events, reset 0.
// (RQ3) reserved control bits are dropped on write and read back 0, with no effect.
// (RQ4) status bits 15..8 are read only and read as 0.
// (RQ5) status bit 7 shows auto-negotiation completed and clears when the status is read.
// (RQ6) status bit 6 latches a speed change until the next status read.
// (RQ7) status bit 5 latches a duplex change until the next status read.
// (RQ8) status bit 4 latches a link change until the next status read.
// (RQ9) status bit 2 reads 1 while an interrupt is pending.
// (RQ10) the active-low interrupt asserts on enabled flags or force and drops once flags clear with force off.
module pmi_intr (
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                arst_n,
    // management register port
    input  wire logic [4:0]          reg_addr,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [15:0]         reg_wdata,
    output logic      [15:0]         reg_rdata,
    // phy state levels from other clock regions
    input  wire logic                autoneg_complete,
    input  wire logic                link_speed,
    input  wire logic                link_duplex,
    input  wire logic                link_up,
    // interrupt pin, active low
    output logic                     mgmt_interrupt_out_n
);
    import pmi_pkg::*;

    // event lanes in the synchronised vector
    localparam int         EV_AUTONEG = 0;
    localparam int         EV_SPEED   = 1;
    localparam int         EV_DUPLEX  = 2;
    localparam int         EV_LINK    = 3;
    // edges after reset until the history holds real input levels
    localparam logic [1:0] PRIME_LAST = 2'(SYNC_STAGES + 1);

    // synchronised inputs and their history
    logic [NUM_EVENTS-1:0] raw_in;
    logic [NUM_EVENTS-1:0] sync_in;
    logic [NUM_EVENTS-1:0] prev_ff;
    logic [1:0]            prime_cnt_ff;
    logic [1:0]            nxt_prime_cnt;
    logic                  primed;
    // per-event edges and sticky flags
    wire  [NUM_EVENTS-1:0] event_hit;
    wire  [NUM_EVENTS-1:0] nxt_flag;
    logic [NUM_EVENTS-1:0] flag_ff;
    logic                  autoneg_done_flag;
    logic                  speed_change_flag;
    logic                  duplex_change_flag;
    logic                  link_change_flag;
    logic                  any_flag;
    // register port decode
    logic                  ctrl_sel;
    logic                  status_sel;
    logic                  ctrl_wr;
    logic                  status_rd;
    // control bits
    logic                  int_en_ff;
    logic                  nxt_int_en;
    logic                  force_ff;
    logic                  nxt_force;
    // read path and pin
    logic                  pending;
    logic [15:0]           ctrl_view;
    logic [15:0]           status_view;
    logic [15:0]           nxt_rdata;
    logic [15:0]           rdata_ff;
    logic                  nxt_int_n;
    logic                  int_n_ff;

    // pins from other clock regions pass two flops before any use
    assign raw_in = {link_up, link_duplex, link_speed, autoneg_complete};

    pmi_sync #(
        .WIDTH (NUM_EVENTS)
    ) u_sync (
        .mclk   (mclk),
        .arst_n (arst_n),
        .din    (raw_in),
        .dout   (sync_in)
    );

    // history counts as valid only once the synchroniser has refilled
    assign primed        = (prime_cnt_ff == PRIME_LAST);
    assign nxt_prime_cnt = primed ? prime_cnt_ff : prime_cnt_ff + 2'h1;

    // priming counter; keeps levels present at reset from posing as events
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prime_cnt_ff <= 2'h0;
        end else begin
            prime_cnt_ff <= nxt_prime_cnt;
        end
    end

    // history of synchronised levels for edge detection
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= sync_in;
        end
    end

    // per event: edge against history, then the flag's next value
    for (genvar g = 0; g < NUM_EVENTS; g++) begin : g_event
        if (g == EV_AUTONEG) begin : g_rise
            // completion counts on its rising edge only
            assign event_hit[g] = primed & sync_in[g] & ~prev_ff[g];  // [RQ5]
        end else begin : g_toggle
            // speed, duplex and link count every change of level
            assign event_hit[g] = primed & (sync_in[g] ^ prev_ff[g]); // [RQ6] [RQ7] [RQ8]
        end
        // a new event in the read cycle wins over the clear
        assign nxt_flag[g] = event_hit[g] | (flag_ff[g] & ~status_rd);
    end

    // sticky event flags
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            flag_ff <= '0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    // named views of the flag lanes
    assign autoneg_done_flag  = flag_ff[EV_AUTONEG];
    assign speed_change_flag  = flag_ff[EV_SPEED];
    assign duplex_change_flag = flag_ff[EV_DUPLEX];
    assign link_change_flag   = flag_ff[EV_LINK];
    assign any_flag           = |flag_ff;

    // register port decode
    assign ctrl_sel   = (reg_addr == ADDR_INT_CTRL);
    assign status_sel = (reg_addr == ADDR_INT_STATUS);
    assign ctrl_wr    = reg_wr & ctrl_sel;
    assign status_rd  = reg_rd & status_sel;

    // next control bits; reserved write bits are not stored
    assign nxt_int_en = ctrl_wr ? reg_wdata[CTRL_EN_BIT] : int_en_ff;    // [RQ1]
    assign nxt_force  = ctrl_wr ? reg_wdata[CTRL_FORCE_BIT] : force_ff;  // [RQ2] [RQ3]

    // interrupt enable bit
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            int_en_ff <= CTRL_RESET[CTRL_EN_BIT];
        end else begin
            int_en_ff <= nxt_int_en;
        end
    end

    // force test bit
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            force_ff <= CTRL_RESET[CTRL_FORCE_BIT];
        end else begin
            force_ff <= nxt_force;
        end
    end

    // pending: enabled flags or the force bit
    assign pending   = force_ff | (int_en_ff & any_flag);                // [RQ10]
    assign nxt_int_n = ~pending;

    // control view; reserved bits read 0
    always_comb begin
        ctrl_view                 = '0;                                  // [RQ3]
        ctrl_view[CTRL_EN_BIT]    = int_en_ff;
        ctrl_view[CTRL_FORCE_BIT] = force_ff;
    end

    // status view; reserved bits read 0
    always_comb begin
        status_view                 = '0;                                // [RQ4]
        status_view[STS_AUTONEG_DONE_FLAG_BIT] = autoneg_done_flag;                 // [RQ5]
        status_view[STS_SPEED_BIT]  = speed_change_flag;                 // [RQ6]
        status_view[STS_DUPLEX_BIT] = duplex_change_flag;                // [RQ7]
        status_view[STS_LINK_BIT]   = link_change_flag;                  // [RQ8]
        status_view[STS_PEND_BIT]   = pending;                           // [RQ9]
    end

    // read mux; the data hold between reads
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_INT_CTRL:   nxt_rdata = ctrl_view;
                ADDR_INT_STATUS: nxt_rdata = status_view;
                default:         nxt_rdata = 16'h0000;
            endcase
        end
    end

    // read data register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // interrupt pin register, one cycle behind pending
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            int_n_ff <= 1'b1;
        end else begin
            int_n_ff <= nxt_int_n;                                       // [RQ10]
        end
    end

    // outputs straight from their flops
    assign reg_rdata            = rdata_ff;
    assign mgmt_interrupt_out_n = int_n_ff;
endmodule : pmi_intr
`default_nettype wire

//--- hdl/pmi_pkg.sv
`default_nettype none
package pmi_pkg;
    // register addresses on the management register port (5 bits)
    localparam logic [4:0]  ADDR_INT_CTRL    = 5'h12;
    localparam logic [4:0]  ADDR_INT_STATUS  = 5'h13;
    // control register fields
    localparam int          CTRL_EN_BIT      = 1;
    localparam int          CTRL_FORCE_BIT   = 2;
    localparam logic [15:0] CTRL_RESET       = 16'h0000;
    // status register fields
    localparam int          STS_AUTONEG_DONE_FLAG_BIT   = 7;
    localparam int          STS_SPEED_BIT    = 6;
    localparam int          STS_DUPLEX_BIT   = 5;
    localparam int          STS_LINK_BIT     = 4;
    localparam int          STS_PEND_BIT     = 2;
    localparam int          NUM_EVENTS       = 4;
    localparam int          SYNC_STAGES      = 2;
endpackage : pmi_pkg
`default_nettype wire

//--- hdl/pmi_sync.sv
`default_nettype none
module pmi_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             arst_n,
    // data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    import pmi_pkg::*;

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // two-flop synchroniser; first stage feeds only the second
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule : pmi_sync
`default_nettype wire

//--- sim/pmi_intr_checker.sv
`default_nettype none
module pmi_intr_checker
    import pmi_pkg::*;
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        arst_n,
    // register port and pin
    input wire logic [4:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        mgmt_interrupt_out_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // address decode
    logic ctl;
    logic sts;
    assign ctl = reg_addr == ADDR_INT_CTRL;
    assign sts = reg_addr == ADDR_INT_STATUS;
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    reset_idle_a: assert property ($rose(arst_n) |-> !reg_rdata && mgmt_interrupt_out_n)
        else $error("outputs not idle after reset");
    sts_rsv_a: assert property (reg_rd && sts
        |=> !reg_rdata[15:8] && !reg_rdata[3] && !reg_rdata[1:0])
        else $error("reserved status bits not zero");
    ctl_rsv_a: assert property (reg_rd && ctl |=> !reg_rdata[15:3] && !reg_rdata[0])
        else $error("reserved control bits not zero");
    unmapped_zero_a: assert property (reg_rd && !ctl && !sts |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    force_pin_a: assert property (reg_wr && ctl && reg_wdata[CTRL_FORCE_BIT]
        |=> ##1 !mgmt_interrupt_out_n) else $error("force did not drive pin");
    off_pin_a: assert property (reg_wr && ctl && !reg_wdata[2:1]
        |=> ##1 mgmt_interrupt_out_n) else $error("pin active while disabled");
    pend_pin_a: assert property (reg_rd && sts
        |=> reg_rdata[STS_PEND_BIT] == !mgmt_interrupt_out_n) else $error("pending bit off pin");
endmodule : pmi_intr_checker
bind pmi_intr pmi_intr_checker u_chk (.mclk, .arst_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .mgmt_interrupt_out_n);
`default_nettype wire

//--- sim/pmi_host.sv
`default_nettype none
module pmi_host (
    // clock
    input  wire logic        mclk,
    // register port
    output logic      [4:0]  reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle port at time zero
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    // one access, one taken edge; released lines show inverted values
    task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] q);
        @(posedge mclk);
        #1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
        @(posedge mclk);
        #1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
        q = reg_rdata;
    endtask : xfer
endmodule : pmi_host
`default_nettype wire

//--- sim/pmi_intr_bench.sv
`default_nettype none
module pmi_intr_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pmi_pkg::*;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic [4:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic [15:0] q;
    logic [3:0]  ev = 4'h0; // autoneg, speed, duplex, link
    logic        irq_n;
    int          failures = 0;
    int          num_checks = 0;
    int          cyc = 0;
    logic [31:0] rows [4] = '{32'h0002_0002, 32'h0004_0004, 32'hFFF9_0000, 32'hFFFF_0006};
    pmi_host u_host (.mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
    pmi_intr u_dut (.mclk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .autoneg_complete(ev[3]), .link_speed(ev[2]), .link_duplex(ev[1]),
        .link_up(ev[0]), .mgmt_interrupt_out_n(irq_n));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out;
        if (failures == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    // clock and hang guard
    initial forever #25 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 1000) begin
            failures++;
            close_out();
        end
    end
    // main sequence
    initial begin
        repeat (5) @(posedge mclk);
        #1 arst_n = 1'b1;
        u_host.xfer(1'b0, ADDR_INT_CTRL, 16'h0000, q);
        check("ctrl reset", q, CTRL_RESET);
        u_host.xfer(1'b0, ADDR_INT_STATUS, 16'h0000, q);
        check("status reset", q, 16'h0000);
        foreach (rows[i]) begin
            u_host.xfer(1'b1, ADDR_INT_CTRL, rows[i][31:16], q);
            u_host.xfer(1'b0, ADDR_INT_CTRL, 16'h0000, q);
            check("ctrl readback", q, rows[i][15:0]);
            check("pin", 16'(irq_n), 16'(!rows[i][CTRL_FORCE_BIT]));
        end
        u_host.xfer(1'b1, ADDR_INT_CTRL, 16'h0002, q);
        for (int i = 0; i < NUM_EVENTS; i++) begin
            ev[i] = ~ev[i];
            #300;
            check("pin on event", 16'(irq_n), 16'h0000);
            u_host.xfer(1'b0, ADDR_INT_STATUS, 16'h0000, q);
            check("status flag", q, 16'h0004 | 16'(1 << (STS_LINK_BIT + i)));
            #100;
            check("pin cleared", 16'(irq_n), 16'h0001);
            u_host.xfer(1'b0, ADDR_INT_STATUS, 16'h0000, q);
            check("status cleared", q, 16'h0000);
        end
        u_host.xfer(1'b1, ADDR_INT_CTRL, 16'h0000, q);
        ev[2] = ~ev[2];
        #300;
        check("pin disabled", 16'(irq_n), 16'h0001);
        u_host.xfer(1'b0, ADDR_INT_STATUS, 16'h0000, q);
        check("status disabled", q, 16'h0040);
        u_host.xfer(1'b0, 5'h1F, 16'h0000, q);
        check("unmapped", q, 16'h0000);
        // a write to an unmapped address changes nothing
        u_host.xfer(1'b1, 5'h1F, 16'hFFFF, q);
        u_host.xfer(1'b0, ADDR_INT_CTRL, 16'h0000, q);
        check("unmapped write", q, 16'h0000);
        // mid-run reset with force on and event inputs held high except speed, which is low
        u_host.xfer(1'b1, ADDR_INT_CTRL, 16'h0004, q);
        u_host.xfer(1'b0, ADDR_INT_CTRL, 16'h0000, q);
        check("force readback", q, 16'h0004);
        @(posedge mclk);
        #1 arst_n = 1'b0;
        #10;
        check("pin in reset", 16'(irq_n), 16'h0001);
        check("rdata in reset", reg_rdata, 16'h0000);
        repeat (5) @(posedge mclk);
        #1 arst_n = 1'b1;
        #300;
        u_host.xfer(1'b0, ADDR_INT_STATUS, 16'h0000, q);
        check("status after reset", q, 16'h0000);
        u_host.xfer(1'b0, ADDR_INT_CTRL, 16'h0000, q);
        check("ctrl after reset", q, CTRL_RESET);
        u_host.xfer(1'b1, ADDR_INT_CTRL, 16'h0002, q);
        #100;
        check("pin after reset", 16'(irq_n), 16'h0001);
        close_out();
    end
endmodule : pmi_intr_bench
`default_nettype wire
